// ---- design/lds_sequencer.sv ----
// lcd drive sequencer with expansion fifo and apb register slave.
// assumes apb master on pclk, power mode from same-clock controller,
// and a free subclock pin that is synchronised here.
//
// Design decisions made here: the placing of the registers and register access over APB.

// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
module lds_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ------------------------------------------------------------
// sequencer
// ------------------------------------------------------------
module lds_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire lds_pkg::lds_pmode_t power_mode,
    input wire logic module_standby,
    input wire logic subclk_pin,
    output lds_pkg::lds_drive_t drive,
    output logic divider_connect,
    output logic drive_supply_on,
    output logic segment_port_mode,
    output lds_pkg::lds_exp_t exp_out,
    output logic exp_oe
);
    import lds_pkg::*;

    lds_ctrl_t ctrl;
    logic [31:0] seg_data;
    lds_status_t status;
    logic [31:0] rd_value;
    logic addr_ok;
    logic exp_write;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [31:0] fifo_word;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [1:0] last_com(input lds_duty_t d);
        case (d)
            DUTY_STATIC: last_com = 2'h0;
            DUTY_HALF: last_com = 2'h1;
            DUTY_THIRD: last_com = 2'h2;
            default: last_com = 2'h3;
        endcase
    endfunction

    function automatic lds_lvl_t com_level(input lds_duty_t d, input logic sel, input logic m);
        if (sel || d == DUTY_STATIC) begin
            com_level = m ? LVL_VSS : LVL_V1;
        end else if (d == DUTY_HALF) begin
            com_level = LVL_V23;
        end else begin
            com_level = m ? LVL_V2 : LVL_V3;
        end
    endfunction

    function automatic lds_lvl_t seg_level(input lds_duty_t d, input logic data, input logic m);
        if (data) begin
            seg_level = m ? LVL_V1 : LVL_VSS;
        end else if (d == DUTY_STATIC || d == DUTY_HALF) begin
            seg_level = m ? LVL_VSS : LVL_V1;
        end else begin
            seg_level = m ? LVL_V3 : LVL_V2;
        end
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // a data push into a full fifo waits in the access phase: back-pressure
    assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
        paddr == ADDR_SEGDATA || paddr == ADDR_EXPDATA;
    assign exp_write = psel && pwrite && paddr == ADDR_EXPDATA;
    assign pready = !(exp_write && !fifo_in_ready);
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        case (paddr)
            ADDR_CTRL: rd_value = ctrl;
            ADDR_STATUS: rd_value = status;
            ADDR_SEGDATA: rd_value = seg_data;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            seg_data <= SEGDATA_RESET;
        end else if (psel && penable && pwrite) begin
            if (paddr == ADDR_CTRL) begin
                ctrl <= pwdata;
                ctrl.rsvd_hi <= '0;
                ctrl.rsvd_lo <= '0;
            end
            if (paddr == ADDR_SEGDATA) begin
                seg_data <= pwdata;
            end
        end
    end

    lds_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(exp_write && penable),
        .in_ready(fifo_in_ready),
        .in_data(pwdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_word)
    );

    // ------------------------------------------------------------
    // clock availability and display tick
    // ------------------------------------------------------------
    logic sub_meta;
    logic sub_sync;
    logic sub_prev;
    logic [1:0] sub_div;
    logic [15:0] presc;
    logic sub_sel;
    logic sys_run;
    logic sub_run;
    logic running;
    logic sub_edge;
    logic tick;
    logic [15:0] sys_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_prev <= 1'b0;
        end else begin
            sub_meta <= subclk_pin;
            sub_sync <= sub_meta;
            sub_prev <= sub_sync;
        end
    end

    assign sub_sel = ctrl.frame_clock_select == CKS_SUB || ctrl.frame_clock_select == CKS_SUB2 ||
        ctrl.frame_clock_select == CKS_SUB4;
    assign sys_run = (power_mode == PM_ACTIVE || power_mode == PM_SLEEP) && !module_standby;
    assign sub_run = power_mode != PM_STANDBY && !module_standby;
    assign running = ctrl.display_active_bit && (sub_sel ? sub_run : sys_run);
    assign sub_edge = sub_sync && !sub_prev && sub_run;
    assign sys_mask = 16'((32'h1 << (ctrl.frame_clock_select[2:0] + SYS_DIV_BASE)) - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= '0;
            sub_div <= '0;
        end else begin
            presc <= sys_run ? presc + 1'b1 : presc;
            sub_div <= sub_edge ? sub_div + 1'b1 : sub_div;
        end
    end

    always_comb begin
        if (!running) begin
            tick = 1'b0;
        end else if (ctrl.frame_clock_select == CKS_SUB) begin
            tick = sub_edge;
        end else if (ctrl.frame_clock_select == CKS_SUB2) begin
            tick = sub_edge && sub_div[0];
        end else if (ctrl.frame_clock_select == CKS_SUB4) begin
            tick = sub_edge && (sub_div == 2'h3);
        end else begin
            tick = (presc & sys_mask) == '0;
        end
    end

    // ------------------------------------------------------------
    // charge / discharge timing
    // ------------------------------------------------------------
    logic charging;
    logic [4:0] phase_cnt;
    logic [4:0] phase_last;

    // charge length 1..8 ticks, discharge 2..16 ticks
    assign phase_last = charging ? 5'((5'h1 << ctrl.charge_period_select[1:0]) - 1'b1) :
        5'((5'h2 << ctrl.charge_period_select[3:2]) - 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charging <= 1'b1;
            phase_cnt <= '0;
        end else if (tick) begin
            if (phase_cnt >= phase_last) begin
                phase_cnt <= '0;
                charging <= !charging;
            end else begin
                phase_cnt <= phase_cnt + 1'b1;
            end
        end
    end

    // divider only taps v2 = 2/3 and v3 = 1/3 of v1 while charging
    assign divider_connect = running && charging;
    assign drive_supply_on = ctrl.drive_supply_switch && power_mode != PM_STANDBY;

    // ------------------------------------------------------------
    // common scan and alternating signal
    // ------------------------------------------------------------
    logic [1:0] com_idx;
    logic alt_m;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_idx <= '0;
            alt_m <= 1'b0;
        end else if (tick) begin
            if (com_idx >= last_com(ctrl.duty_select)) begin
                com_idx <= '0;
                alt_m <= !alt_m;
            end else begin
                com_idx <= com_idx + 1'b1;
            end
        end
    end

    assign segment_port_mode = ctrl.segment_expansion_enable;

    // halted panel sits at vss so no dc is left across it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= '0;
        end else begin
            for (int c = 0; c < NCOM; c++) begin
                drive.com[c] <= running ? com_level(ctrl.duty_select, com_idx == 2'(c), alt_m) : LVL_VSS;
            end
            for (int s = 0; s < NSEG; s++) begin
                drive.segment_pin[s] <= (running && !ctrl.segment_expansion_enable) ?
                    seg_level(ctrl.duty_select, seg_data[s*NCOM + com_idx], alt_m) : LVL_VSS;
            end
        end
    end

    // ------------------------------------------------------------
    // segment expansion port
    // ------------------------------------------------------------
    logic [4:0] bit_idx;
    logic [6:0] seg_cnt;
    logic exp_go;

    assign exp_go = tick && ctrl.segment_expansion_enable;
    assign fifo_pop = exp_go && fifo_out_valid && exp_out.shift_clock && bit_idx == 5'(WORD_BITS - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_out <= '0;
            bit_idx <= '0;
            seg_cnt <= '0;
        end else if (!ctrl.display_active_bit) begin
            exp_out.shift_clock <= 1'b0;
            exp_out.latch_clock <= 1'b0;
        end else if (exp_go) begin
            exp_out.alt <= alt_m;
            exp_out.latch_clock <= 1'b0;
            if (exp_out.shift_clock) begin
                exp_out.shift_clock <= 1'b0;
                bit_idx <= bit_idx + 1'b1;
                if (seg_cnt == EXP_SEGS - 1'b1) begin
                    seg_cnt <= '0;
                    exp_out.latch_clock <= 1'b1;
                end else begin
                    seg_cnt <= seg_cnt + 1'b1;
                end
            end else if (fifo_out_valid) begin
                // lsb of the first word is the first segment location
                exp_out.data <= fifo_word[bit_idx] ^ alt_m;
                exp_out.shift_clock <= 1'b1;
            end
        end
    end

    assign exp_oe = ctrl.segment_expansion_enable && power_mode != PM_STANDBY;

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_comb begin
        status = '0;
        status.display_running = running;
        status.supply_on = drive_supply_on;
        status.alt_signal = alt_m;
        status.charge_phase = charging;
        status.fifo_full = !fifo_in_ready;
        status.fifo_empty = !fifo_out_valid;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_halt_inactive: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl.display_active_bit |=> drive.com[0] == LVL_VSS) else $error("display not halted");
    a_standby_supply: assert property (@(posedge pclk) disable iff (!presetn)
        power_mode == PM_STANDBY |-> !drive_supply_on && !running) else $error("standby supply on");
    a_mstby_halt: assert property (@(posedge pclk) disable iff (!presetn)
        module_standby |-> !running && !tick) else $error("module standby running");
    a_subclk_only: assert property (@(posedge pclk) disable iff (!presetn)
        (power_mode == PM_WATCH && !sub_sel) |-> !running) else $error("sys clock in watch");
    a_charge_alt: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(charging) |-> ##[1:1000] $fell(charging) or !running) else $error("no discharge");
    a_exp_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl.display_active_bit ##1 !ctrl.display_active_bit |-> $stable(exp_out.data) &&
        !exp_out.shift_clock && !exp_out.latch_clock) else $error("expansion not frozen");
    a_exp_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        power_mode == PM_STANDBY |-> !exp_oe) else $error("expansion driven in standby");
    a_static_seg: assert property (@(posedge pclk) disable iff (!presetn)
        running && ctrl.duty_select == DUTY_STATIC && !ctrl.segment_expansion_enable && !seg_data[0]
        && $stable(ctrl) |=> drive.segment_pin[0] == drive.com[0]) else $error("static segment mismatch");
    a_half_unsel: assert property (@(posedge pclk) disable iff (!presetn)
        running && ctrl.duty_select == DUTY_HALF && com_idx == 2'h0 && $stable(ctrl)
        |=> drive.com[1] == LVL_V23) else $error("half duty unselected level");

    c_charge_cycle: cover property (@(posedge pclk) disable iff (!presetn) $fell(charging));
    c_exp_latch: cover property (@(posedge pclk) disable iff (!presetn) exp_out.latch_clock);
    c_fifo_full: cover property (@(posedge pclk) disable iff (!presetn) exp_write && !pready);
    c_sub_run: cover property (@(posedge pclk) disable iff (!presetn) running && power_mode == PM_WATCH);
endmodule

// ---- design/lds_pkg.sv ----
// lcd drive sequencer: shared constants, register layouts and types.
// assumes an apb master on pclk and a power controller on the same clock.
package lds_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SEGDATA = 8'h08;
    localparam logic [7:0] ADDR_EXPDATA = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEGDATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // sizes and clock selection
    // ------------------------------------------------------------
    localparam int NCOM = 4;
    localparam int NSEG = 8;
    localparam int WORD_BITS = 32;
    localparam int FIFO_DEPTH = 16;
    localparam logic [6:0] EXP_SEGS = 7'h50;
    localparam logic [3:0] CKS_SUB = 4'h8;
    localparam logic [3:0] CKS_SUB2 = 4'h9;
    localparam logic [3:0] CKS_SUB4 = 4'ha;
    localparam logic [4:0] SYS_DIV_BASE = 5'h04;

    typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} lds_duty_t;
    typedef enum logic [2:0] {LVL_VSS, LVL_V1, LVL_V2, LVL_V3, LVL_V23} lds_lvl_t;
    typedef enum logic [2:0] {
        PM_ACTIVE, PM_SLEEP, PM_WATCH, PM_SUBACTIVE, PM_SUBSLEEP, PM_STANDBY
    } lds_pmode_t;

    // ------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] rsvd_hi;
        logic [3:0] segment_group_select;
        logic [3:0] charge_period_select;
        logic [3:0] frame_clock_select;
        logic [2:0] rsvd_lo;
        lds_duty_t duty_select;
        logic segment_expansion_enable;
        logic drive_supply_switch;
        logic display_active_bit;
    } lds_ctrl_t;

    typedef struct packed {
        logic [25:0] rsvd;
        logic fifo_empty;
        logic fifo_full;
        logic charge_phase;
        logic alt_signal;
        logic supply_on;
        logic display_running;
    } lds_status_t;

    typedef struct packed {
        lds_lvl_t [NCOM-1:0] com;
        lds_lvl_t [NSEG-1:0] segment_pin;
    } lds_drive_t;

    typedef struct packed {
        logic shift_clock;
        logic latch_clock;
        logic data;
        logic alt;
    } lds_exp_t;
endpackage

// ---- verification/lds_expander_model.sv ----
// cascaded segment expander model: collects shifted bits and latch pulses.
// assumes the sequencer's expansion pins on the same pclk.
module lds_expander_model
    import lds_pkg::*;
(
    input wire logic pclk,
    input wire lds_pkg::lds_exp_t exp_in,
    input wire logic oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic bits[$];
    int n_latch = 0;
    logic last_sc = 1'b0;
    logic last_lc = 1'b0;
    // bits are taken on the shift clock rise; level undone with alt
    always @(posedge pclk) begin
        if (oe && exp_in.shift_clock && !last_sc)
            bits.push_back(exp_in.data ^ exp_in.alt);
        if (oe && exp_in.latch_clock && !last_lc)
            n_latch++;
        last_sc <= exp_in.shift_clock;
        last_lc <= exp_in.latch_clock;
    end
endmodule

// ---- verification/testbench.sv ----
// testbench: bus, frame levels, charge timing, power modes, expansion stream.
// assumes a free subclock and the expander model on the expansion pins.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import lds_pkg::*;
    logic pclk, subclk_pin, pready, pslverr, rd_e, divider_connect, drive_supply_on, segment_port_mode, exp_oe, d;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, module_standby = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_v, seed = 32'haac2ed90;
    lds_pmode_t power_mode = PM_ACTIVE;
    lds_drive_t drive;
    lds_exp_t exp_out;
    logic [31:0] words[17];
    // mode, module standby, frame clock, act, running, supply
    logic [11:0] tab[10] = '{12'h00e, 12'h002, 12'h20e, 12'h40a, 12'h48e, 12'h69e, 12'h8ae, 12'h63a, 12'ha88,
        12'h10a};
    int n_errors = 0;
    int compares = 0;
    int n;

    lds_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_mode(power_mode), .module_standby(module_standby), .subclk_pin(subclk_pin), .drive(drive),
        .divider_connect(divider_connect), .drive_supply_on(drive_supply_on),
        .segment_port_mode(segment_port_mode), .exp_out(exp_out), .exp_oe(exp_oe));
    lds_expander_model ext (.pclk(pclk), .exp_in(exp_out), .oe(exp_oe));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge pclk);
    endtask
    // an idle cycle before each setup keeps psel from being assigned twice at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 5000);
        // a slave that never answers counts against the verdict
        if (pready !== 1'b1)
            n_errors++;
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [31:0] ctl(input logic [2:0] f, input logic [1:0] du, input logic [3:0] ck,
        input logic [3:0] cd);
        return {16'h0, cd, ck, 3'h0, du, f};
    endfunction
    function automatic lds_lvl_t ecom(input lds_duty_t du, input logic alt, input logic sel);
        if (sel)
            return alt ? LVL_VSS : LVL_V1;
        return du == DUTY_HALF ? LVL_V23 : (alt ? LVL_V2 : LVL_V3);
    endfunction
    function automatic lds_lvl_t eseg(input lds_duty_t du, input logic alt, input logic dat);
        if (du < DUTY_THIRD)
            return alt ^ dat ? LVL_VSS : LVL_V1;
        return dat ? (alt ? LVL_V1 : LVL_VSS) : (alt ? LVL_V3 : LVL_V2);
    endfunction
    task automatic wait_dc(input logic v, output int c);
        c = 0;
        while (divider_connect !== v && c < 5000) begin
            @(negedge pclk);
            c++;
        end
    endtask
    // the selected common reveals alt, so no status read races the tick
    task automatic frame(input lds_duty_t du, input logic [31:0] sd);
        int s;
        logic alt;
        cyc(4);
        repeat (8) begin
            cyc(16);
            s = 0;
            for (int c = 1; c <= int'(du); c++)
                if (drive.com[c] inside {LVL_V1, LVL_VSS})
                    s = c;
            alt = drive.com[s] === LVL_VSS;
            for (int c = 0; c <= int'(du); c++)
                cmp(drive.com[c], ecom(du, alt, c == s));
            for (int g = 0; g < NSEG; g++)
                cmp(drive.segment_pin[g], eseg(du, alt, sd[g*4+s]));
        end
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        subclk_pin = 1'b0;
        forever #137 subclk_pin = ~subclk_pin;
    end
    initial begin
        #3000000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge pclk);
        cmp(drive, 0);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 0);
        cmp(rd_v, CTRL_RESET);
        apb(1'b0, ADDR_SEGDATA, 0);
        cmp(rd_v, SEGDATA_RESET);
        apb(1'b1, ADDR_CTRL, 32'hffffffff);
        apb(1'b0, ADDR_CTRL, 0);
        cmp(rd_v, 32'h000fff1f);
        apb(1'b0, 8'h10, 0);
        cmp({rd_e, rd_v}, 33'h100000000);
        for (int du = 0; du < 4; du++) begin
            words[0] = rnd();
            apb(1'b1, ADDR_SEGDATA, words[0]);
            apb(1'b1, ADDR_CTRL, ctl(3'b011, du[1:0], 4'h0, 4'h5));
            frame(lds_duty_t'(du), words[0]);
        end
        for (int k = 0; k < 3; k++) begin
            words[1] = k == 0 ? 32'hf : rnd();
            apb(1'b1, ADDR_CTRL, ctl(3'b011, 2'd2, 4'h0, words[1][3:0]));
            wait_dc(1'b0, n);
            wait_dc(1'b1, n);
            wait_dc(1'b0, n);
            cmp(n, 16 << words[1][1:0]);
            wait_dc(1'b1, n);
            cmp(n, 32 << words[1][3:2]);
        end
        foreach (tab[i]) begin
            @(posedge pclk);
            power_mode <= lds_pmode_t'(tab[i][11:9]);
            module_standby <= tab[i][8];
            apb(1'b1, ADDR_CTRL, ctl({2'b01, tab[i][3]}, 2'd2, tab[i][7:4], 4'h0));
            cyc(150);
            apb(1'b0, ADDR_STATUS, 0);
            cmp({drive_supply_on, rd_v[1:0]}, {tab[i][1], tab[i][1], tab[i][2]});
            if (!tab[i][2])
                cmp(drive, 0);
        end
        power_mode <= PM_ACTIVE;
        module_standby <= 1'b0;
        apb(1'b1, ADDR_CTRL, ctl(3'b110, 2'd0, 4'h0, 4'h0));
        for (int i = 0; i < 16; i++) begin
            words[i] = rnd();
            apb(1'b1, ADDR_EXPDATA, words[i]);
        end
        cmp({segment_port_mode, exp_oe}, 2'b11);
        apb(1'b0, ADDR_STATUS, 0);
        cmp(rd_v[5:4], 2'b01);
        apb(1'b1, ADDR_CTRL, ctl(3'b111, 2'd0, 4'h0, 4'h0));
        words[16] = rnd();
        apb(1'b1, ADDR_EXPDATA, words[16]);
        n = 0;
        while (ext.bits.size() < 544 && n < 40000) begin
            cyc(1);
            n++;
        end
        // the last word only pops on the falling shift tick, one tick after its last bit
        cyc(32);
        cmp(ext.bits.size(), 544);
        foreach (ext.bits[i])
            cmp(ext.bits[i], words[i/32][i%32]);
        cmp(ext.n_latch, 6);
        apb(1'b0, ADDR_STATUS, 0);
        cmp(rd_v[5:4], 2'b10);
        apb(1'b1, ADDR_EXPDATA, 32'h5a5a5a5a);
        cyc(100);
        apb(1'b1, ADDR_CTRL, ctl(3'b110, 2'd0, 4'h0, 4'h0));
        cyc(2);
        d = exp_out.data;
        repeat (20) begin
            cyc(3);
            cmp(exp_out, {2'b00, d, exp_out.alt});
        end
        @(posedge pclk);
        power_mode <= PM_STANDBY;
        cyc(2);
        cmp(exp_oe, 1'b0);
        report_and_stop();
    end
endmodule
